// file: hdl/lds_serial_port.sv
`timescale 1ns/1ps
// What this block does
// - While frame select is low, each falling serial clock edge shifts serial_in into the shift register, up to 30 MHz.
// - serial_out changes on each rising serial clock edge so it is stable at the next falling edge.
// - Transfers are framed by frame select held low; data moves only on falling edges inside a frame.
// - At the rising edge of frame select the accumulated word is captured and handed to the registers.
// - With load_output_n held low, a new value reaches the output register at the frame's close.
// - With load_output_n high, only the input register is written; the output waits for its falling edge.
// - The alert output is high whenever any monitored fault is present.
// - Faults are loss of serial control, packet_check failure, loop current out of range, low loop voltage, overtemperature.
// - A high alarm-direction strap selects the upscale alarm current, a low one the downscale alarm.
// - A high sense_resistor_sel strap selects the internal resistor, a low one the external path.
// - The two span strap inputs are decoded into a loop current range selection.
module lds_serial_port
  import lds_pkg::*;
#(
  parameter int WDOG_CYCLES = LDS_WDOG_CYCLES,
  parameter logic [3:0][1:0] SPAN_MAP = LDS_SPAN_MAP_RST
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic load_output_n,
  input wire lds_ana_t ana_fault,
  input wire logic alarm_dir,
  input wire logic sense_resistor_sel,
  input wire logic span_sel_lo,
  input wire logic span_sel_hi,
  input wire lds_bus_req_t bus_req,
  output logic [LDS_DATA_W-1:0] bus_rdata,
  output logic alert,
  output logic [LDS_DATA_W-1:0] dac_code,
  output logic load_pending,
  output lds_strap_t strap_out
);

  localparam int WDOG_W = $clog2(WDOG_CYCLES + 1);
  localparam logic [WDOG_W-1:0] WDOG_LAST = WDOG_W'(WDOG_CYCLES - 1);

  if (WDOG_CYCLES < 2)
  begin : g_wdog_chk
    $error("WDOG_CYCLES must be at least 2");
  end

  // ==========================================================================
  // Link side, on the serial clock
  // No reset here: the serial clock only runs inside frames, and the word is
  // taken over by the core domain once the frame has closed.
  // Power-up value only: the link has no reset pin, and a known start keeps
  // the first frames from shifting unknown bits out on serial_out.
  logic [LDS_SHIFT_W-1:0] lnk_shift_reg = '0;
  logic [LDS_SHIFT_W-1:0] lnk_shift_next;
  logic sout_reg = 1'b0;

  always_comb
  begin
    if (frame_n)
      lnk_shift_next = lnk_shift_reg;
    else
      lnk_shift_next = {lnk_shift_reg[LDS_SHIFT_W-2:0], serial_in};
  end

  always_ff @(negedge sclk)
  begin
    lnk_shift_reg <= lnk_shift_next;
  end

  // Daisy-chain style: the bit leaving the shift register goes out half a clock later
  always_ff @(posedge sclk)
  begin
    sout_reg <= lnk_shift_reg[LDS_SHIFT_W-1];
  end

  assign serial_out = sout_reg;

  // ==========================================================================
  // Core state
  typedef struct packed {
    logic [1:0] frame_sync;
    logic [1:0] load_sync;
    logic [2:0] ana_s1;
    logic [2:0] ana_s2;
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;
    logic frame_prev;
    logic load_prev;
    logic close;
    logic [LDS_SHIFT_W-1:0] frame_word;
    logic [LDS_DATA_W-1:0] input_reg;
    logic [LDS_DATA_W-1:0] dac_reg;
    logic [LDS_CTRL_W-1:0] ctrl;
    logic [LDS_FLT_W-1:0] fault;
    logic alert;
    lds_strap_t strap;
    lds_load_state_t ld_state;
    logic [WDOG_W-1:0] wdog_cnt;
    logic [LDS_DATA_W-1:0] rdata;
  } lds_core_t;

  lds_core_t s_reg;
  lds_core_t s_next;

  logic [LDS_FRAME_W-1:0] word;
  logic pec_bad;
  logic take_new;
  logic ld_fall;
  logic frame_rise;

  // ==========================================================================
  // Core next state
  always_comb
  begin
    s_next = s_reg;
    word = s_reg.ctrl[LDS_CTRL_PEC_EN] ? s_reg.frame_word[LDS_SHIFT_W-1:LDS_PEC_W]
                                       : s_reg.frame_word[LDS_FRAME_W-1:0];
    pec_bad = s_reg.ctrl[LDS_CTRL_PEC_EN]
              && (lds_crc8(word) != s_reg.frame_word[LDS_PEC_W-1:0]);
    take_new = s_reg.close && !pec_bad
               && (word[LDS_FRAME_W-1:LDS_CMD_POS] == LDS_CMD_LOAD);
    ld_fall = s_reg.load_prev && !s_reg.load_sync[1];
    frame_rise = s_reg.frame_sync[1] && !s_reg.frame_prev;

    // Synchronisers: stage one only feeds stage two
    s_next.frame_sync = {s_reg.frame_sync[0], frame_n};
    s_next.load_sync = {s_reg.load_sync[0], load_output_n};
    s_next.ana_s1 = ana_fault;
    s_next.ana_s2 = s_reg.ana_s1;
    s_next.strap_s1 = {alarm_dir, sense_resistor_sel, span_sel_hi, span_sel_lo};
    s_next.strap_s2 = s_reg.strap_s1;
    s_next.frame_prev = s_reg.frame_sync[1];
    s_next.load_prev = s_reg.load_sync[1];

    // The shift register is quiet once frame select is high, so it is read
    // directly; the host must leave frame select high for four core clocks.
    s_next.close = frame_rise;
    if (frame_rise)
      s_next.frame_word = lnk_shift_reg;

    case (s_reg.ld_state)
      LDS_LD_IDLE:
      begin
        if (take_new && s_reg.load_sync[1])
          s_next.ld_state = LDS_LD_PENDING;
      end
      LDS_LD_PENDING:
      begin
        if (take_new && !s_reg.load_sync[1])
          s_next.ld_state = LDS_LD_IDLE;
        else if (!take_new && ld_fall)
          s_next.ld_state = LDS_LD_IDLE;
      end
      default:
      begin
        s_next.ld_state = LDS_LD_IDLE;
      end
    endcase

    if (take_new)
    begin
      s_next.input_reg = word[LDS_DATA_W-1:0];
      if (!s_reg.load_sync[1])
        s_next.dac_reg = word[LDS_DATA_W-1:0];
    end
    else if (ld_fall)
    begin
      s_next.dac_reg = s_reg.input_reg;
    end

    // Loss of serial control: no closed frame within the window
    if (!s_reg.ctrl[LDS_CTRL_WDOG_EN] || s_reg.close)
      s_next.wdog_cnt = '0;
    else if (s_reg.wdog_cnt != WDOG_LAST)
      s_next.wdog_cnt = s_reg.wdog_cnt + 1'b1;

    // Sticky faults: a software clear first, so a same-cycle set wins
    if (bus_req.wr && bus_req.addr == LDS_REG_FAULT)
    begin
      s_next.fault[LDS_FLT_WDOG] = s_reg.fault[LDS_FLT_WDOG] & ~bus_req.wdata[LDS_FLT_WDOG];
      s_next.fault[LDS_FLT_PEC] = s_reg.fault[LDS_FLT_PEC] & ~bus_req.wdata[LDS_FLT_PEC];
    end
    if (s_reg.ctrl[LDS_CTRL_WDOG_EN] && !s_reg.close && s_reg.wdog_cnt == WDOG_LAST)
      s_next.fault[LDS_FLT_WDOG] = 1'b1;
    if (s_reg.close && pec_bad)
      s_next.fault[LDS_FLT_PEC] = 1'b1;
    s_next.fault[LDS_FLT_TEMP:LDS_FLT_CURRENT] = s_reg.ana_s2;
    s_next.alert = |s_reg.fault;

    s_next.strap.alarm_up = s_reg.strap_s2[3];
    s_next.strap.int_res = s_reg.strap_s2[2];
    s_next.strap.span_code = SPAN_MAP[s_reg.strap_s2[1:0]];

    if (bus_req.wr && bus_req.addr == LDS_REG_CTRL)
      s_next.ctrl = bus_req.wdata[LDS_CTRL_W-1:0];

    s_next.rdata = '0;
    if (bus_req.rd)
    begin
      if (bus_req.addr == LDS_REG_CTRL)
        s_next.rdata = LDS_DATA_W'(s_reg.ctrl);
      else if (bus_req.addr == LDS_REG_FAULT)
        s_next.rdata = LDS_DATA_W'(s_reg.fault);
      else if (bus_req.addr == LDS_REG_INPUT)
        s_next.rdata = s_reg.input_reg;
      else if (bus_req.addr == LDS_REG_OUTPUT)
        s_next.rdata = s_reg.dac_reg;
      else if (bus_req.addr == LDS_REG_STRAP)
        s_next.rdata = LDS_DATA_W'({s_reg.ld_state == LDS_LD_PENDING, s_reg.strap});
      else if (bus_req.addr == LDS_REG_FRAME)
        s_next.rdata = LDS_DATA_W'(s_reg.frame_word[LDS_FRAME_W-1:LDS_CMD_POS]);
      else
        s_next.rdata = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.frame_sync <= 2'h3;
      s_reg.load_sync <= 2'h3;
      s_reg.frame_prev <= 1'b1;
      s_reg.load_prev <= 1'b1;
      s_reg.ctrl <= LDS_CTRL_RST;
      s_reg.dac_reg <= LDS_DAC_RST;
      s_reg.ld_state <= LDS_LD_IDLE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign bus_rdata = s_reg.rdata;
  assign alert = s_reg.alert;
  assign dac_code = s_reg.dac_reg;
  assign load_pending = (s_reg.ld_state == LDS_LD_PENDING);
  assign strap_out = s_reg.strap;

  // ==========================================================================
  // Checks on the serial clock
  shift_in_a: assert property (@(negedge sclk) !frame_n |=>
    lnk_shift_reg[LDS_SHIFT_W-1:1] == $past(lnk_shift_reg[LDS_SHIFT_W-2:0])
    && lnk_shift_reg[0] == $past(serial_in))
    else $error("shift register did not take serial_in");

  idle_hold_a: assert property (@(negedge sclk) frame_n |=> $stable(lnk_shift_reg))
    else $error("shift register moved outside a frame");

  sout_follow_a: assert property (@(posedge sclk) 1'b1 |=>
    serial_out == $past(lnk_shift_reg[LDS_SHIFT_W-1]))
    else $error("serial_out not updated on rising edge");

  // ==========================================================================
  // Checks on the core clock
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence frame_closes_s;
    $rose(s_reg.frame_sync[1]);
  endsequence

  sequence load_word_s;
    s_reg.close && !pec_bad && word[LDS_FRAME_W-1:LDS_CMD_POS] == LDS_CMD_LOAD;
  endsequence

  frame_capture_a: assert property (frame_closes_s |=>
    s_reg.frame_word == $past(lnk_shift_reg) && s_reg.close)
    else $error("frame word not captured at frame close");

  load_now_a: assert property ((load_word_s and !s_reg.load_sync[1]) |=>
    dac_code == s_reg.input_reg && !load_pending)
    else $error("output not loaded at frame close");

  load_defer_a: assert property ((load_word_s and s_reg.load_sync[1]) |=>
    load_pending && dac_code == $past(dac_code))
    else $error("output changed while load strobe high");

  load_fall_a: assert property ((load_pending && ld_fall && !s_reg.close) |=>
    dac_code == $past(s_reg.input_reg) && !load_pending)
    else $error("deferred load missed strobe fall");

  alert_track_a: assert property (1'b1 |=> alert == $past(s_reg.fault != '0))
    else $error("alert does not follow faults");

  pec_fault_a: assert property ((s_reg.close && pec_bad) |=>
    s_reg.fault[LDS_FLT_PEC] ##1 alert)
    else $error("packet_check failure not flagged");

  ana_fault_a: assert property (ana_fault.over_temp [*3] |->
    s_next.fault[LDS_FLT_TEMP] ##2 alert)
    else $error("overtemperature not flagged");

  strap_reg_a: assert property ($changed(alarm_dir) |-> ##3
    (strap_out.alarm_up == $past(alarm_dir, 3)))
    else $error("alarm strap not registered");

  span_map_a: assert property (1'b1 |-> ##3
    strap_out.span_code == SPAN_MAP[$past(s_reg.strap_s1[1:0], 2)])
    else $error("span code not decoded");

  // ==========================================================================
  // Register port and fault flags
  rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == '0)
    else $error("read data not cleared after the read cycle");

  rdata_out_a: assert property ((bus_req.rd && bus_req.addr == LDS_REG_OUTPUT) |=>
    bus_rdata == $past(dac_code))
    else $error("output register read back wrong");

  fault_read_a: assert property ((bus_req.rd && bus_req.addr == LDS_REG_FAULT) |=>
    bus_rdata[LDS_FLT_W-1:0] == $past(s_reg.fault))
    else $error("fault register read back wrong");

  wdog_fault_a: assert property ((s_reg.ctrl[LDS_CTRL_WDOG_EN] && !s_reg.close
    && s_reg.wdog_cnt == WDOG_LAST) |=> s_reg.fault[LDS_FLT_WDOG])
    else $error("loss of serial control not flagged");

  // A clear must not swallow a check failure landing in the same cycle
  fault_clear_a: assert property ((bus_req.wr && bus_req.addr == LDS_REG_FAULT
    && bus_req.wdata[LDS_FLT_PEC] && !(s_reg.close && pec_bad))
    |=> !s_reg.fault[LDS_FLT_PEC])
    else $error("packet_check fault not cleared");

  frame_quiet_a: assert property ((!frame_rise && !s_reg.close) |=>
    $stable(s_reg.frame_word))
    else $error("frame word moved without a frame close");

endmodule

// file: hdl/lds_pkg.sv
package lds_pkg;

  // ==========================================================================
  // Widths and frame layout
  localparam int LDS_DATA_W = 16;
  localparam int LDS_CMD_W = 8;
  localparam int LDS_FRAME_W = 24;
  localparam int LDS_PEC_W = 8;
  localparam int LDS_SHIFT_W = LDS_FRAME_W + LDS_PEC_W;
  localparam int LDS_ADDR_W = 4;
  localparam int LDS_CMD_POS = 16;
  localparam logic [LDS_PEC_W-1:0] LDS_PEC_POLY = 8'h07;
  localparam logic [LDS_PEC_W-1:0] LDS_PEC_SEED = 8'h00;
  localparam logic [LDS_CMD_W-1:0] LDS_CMD_LOAD = 8'h01;

  // ==========================================================================
  // Register offsets
  localparam logic [LDS_ADDR_W-1:0] LDS_REG_CTRL = 4'h0;
  localparam logic [LDS_ADDR_W-1:0] LDS_REG_FAULT = 4'h1;
  localparam logic [LDS_ADDR_W-1:0] LDS_REG_INPUT = 4'h2;
  localparam logic [LDS_ADDR_W-1:0] LDS_REG_OUTPUT = 4'h3;
  localparam logic [LDS_ADDR_W-1:0] LDS_REG_STRAP = 4'h4;
  localparam logic [LDS_ADDR_W-1:0] LDS_REG_FRAME = 4'h5;

  // ==========================================================================
  // Field positions
  localparam int LDS_CTRL_PEC_EN = 0;
  localparam int LDS_CTRL_WDOG_EN = 1;
  localparam int LDS_CTRL_W = 2;
  localparam int LDS_FLT_WDOG = 0;
  localparam int LDS_FLT_PEC = 1;
  localparam int LDS_FLT_CURRENT = 2;
  localparam int LDS_FLT_VOLTAGE = 3;
  localparam int LDS_FLT_TEMP = 4;
  localparam int LDS_FLT_W = 5;

  // ==========================================================================
  // Reset values
  localparam logic [LDS_CTRL_W-1:0] LDS_CTRL_RST = 2'h0;
  localparam logic [LDS_DATA_W-1:0] LDS_DAC_RST = 16'h0000;
  localparam logic [3:0][1:0] LDS_SPAN_MAP_RST = 8'hE4;

  // ==========================================================================
  // Timing
  localparam int LDS_CORE_CLK_HZ = 25_000_000;
  localparam int LDS_SCLK_MAX_HZ = 30_000_000;
  localparam int LDS_WDOG_TIME_US = 1000;
  localparam int LDS_WDOG_CYCLES = LDS_WDOG_TIME_US * (LDS_CORE_CLK_HZ / 1_000_000);

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    LDS_LD_IDLE = 2'b00,
    LDS_LD_PENDING = 2'b01
  } lds_load_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [LDS_ADDR_W-1:0] addr;
    logic [LDS_DATA_W-1:0] wdata;
  } lds_bus_req_t;

  typedef struct packed {
    logic alarm_up;
    logic int_res;
    logic [1:0] span_code;
  } lds_strap_t;

  typedef struct packed {
    logic over_temp;
    logic loop_volt_low;
    logic loop_cur_bad;
  } lds_ana_t;

  function automatic logic [LDS_PEC_W-1:0] lds_crc8(input logic [LDS_FRAME_W-1:0] d);
    logic [LDS_PEC_W-1:0] c;
    c = LDS_PEC_SEED;
    for (int i = LDS_FRAME_W - 1; i >= 0; i--)
    begin
      if (c[LDS_PEC_W-1] ^ d[i])
        c = {c[LDS_PEC_W-2:0], 1'b0} ^ LDS_PEC_POLY;
      else
        c = {c[LDS_PEC_W-2:0], 1'b0};
    end
    return c;
  endfunction

endpackage

// file: testbench/lds_host_model.sv
`timescale 1ns/1ps
// ============================================================
// Host side of the serial link
module lds_host_model
(
  output logic sclk,
  output logic frame_n,
  output logic serial_in,
  input wire logic serial_out
);
  logic [31:0] rx_word;

  initial
  begin
    sclk = 1'b1;
    frame_n = 1'b1;
    serial_in = 1'b0;
    rx_word = 32'h0000_0000;
  end

  // Clock idles high and stands still outside frames
  task automatic send(input logic [31:0] w, input int n);
    #7;
    frame_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = w[i];
      #40;
      rx_word = {rx_word[30:0], serial_out};
      sclk = 1'b0;
      #80;
      sclk = 1'b1;
      #40;
    end
    frame_n = 1'b1;
    // Released line shows the inverse so a stale bit is never mistaken for data
    serial_in = ~serial_in;
    #320;
  endtask
endmodule

// file: testbench/loop_dac_serial_port_tb.sv
`timescale 1ns/1ps
// ============================================================
// Bench
module loop_dac_serial_port_tb;
  import lds_pkg::*;
  localparam int WDOG_SIM = 20;
  // Reversed span table, so a lookup that ignores the table is caught
  localparam logic [3:0][1:0] SPAN_SIM = 8'h1B;
  logic core_clk, rst, sclk, frame_n, serial_in, serial_out, load_output_n, alert, load_pending;
  logic alarm_dir, sense_resistor_sel, span_sel_lo, span_sel_hi;
  logic [LDS_DATA_W-1:0] bus_rdata, dac_code;
  lds_ana_t ana_fault;
  lds_bus_req_t bus_req;
  lds_strap_t strap_out;
  int failures, total_checks, cycles;

  lds_serial_port #(.WDOG_CYCLES(WDOG_SIM), .SPAN_MAP(SPAN_SIM)) i_dut (.core_clk(core_clk),
    .rst(rst), .sclk(sclk),
    .frame_n(frame_n), .serial_in(serial_in), .serial_out(serial_out),
    .load_output_n(load_output_n), .ana_fault(ana_fault), .alarm_dir(alarm_dir),
    .sense_resistor_sel(sense_resistor_sel), .span_sel_lo(span_sel_lo),
    .span_sel_hi(span_sel_hi), .bus_req(bus_req), .bus_rdata(bus_rdata), .alert(alert),
    .dac_code(dac_code), .load_pending(load_pending), .strap_out(strap_out));
  lds_host_model i_host (.sclk(sclk), .frame_n(frame_n), .serial_in(serial_in),
    .serial_out(serial_out));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus_req <= '0;
  endtask

  task automatic bus_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
    check(bus_rdata, exp, "register read");
  endtask

  // Check byte computed here on its own, MSB first
  function automatic logic [7:0] crc_of(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    return c;
  endfunction

  task automatic t_straps();
    for (int v = 0; v < 16; v++)
    begin
      @(posedge core_clk);
      {alarm_dir, sense_resistor_sel, span_sel_hi, span_sel_lo} <= 4'(v);
      repeat (6) @(posedge core_clk);
      check(strap_out, {v[3:2], SPAN_SIM[v[1:0]]}, "straps");
    end
  endtask

  task automatic t_frames();
    i_host.send(32'h0001_A5C3, 24);
    check(dac_code, 16'hA5C3, "immediate load");
    bus_rd(LDS_REG_INPUT, 16'hA5C3);
    i_host.send(32'h0002_1111, 24);
    check(dac_code, 16'hA5C3, "other command");
    bus_rd(LDS_REG_FRAME, 16'h0002);
    @(posedge core_clk);
    load_output_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    i_host.send(32'h0001_3C5A, 24);
    check(dac_code, 16'hA5C3, "held output");
    check(load_pending, 1'b1, "pending");
    @(posedge core_clk);
    load_output_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    check(dac_code, 16'h3C5A, "strobed load");
    check(load_pending, 1'b0, "pending clear");
    i_host.send(32'hC301_1234, 32);
    i_host.send(32'h9E01_ABCD, 32);
    check(i_host.rx_word, 32'hC301_1234, "shifted out");
    check(dac_code, 16'hABCD, "last 24 bits");
  endtask

  task automatic t_faults();
    for (int i = 0; i < 3; i++)
    begin
      @(posedge core_clk);
      ana_fault <= lds_ana_t'(3'b001 << i);
      repeat (6) @(posedge core_clk);
      check(alert, 1'b1, "alert up");
      bus_rd(LDS_REG_FAULT, 16'h0004 << i);
      ana_fault <= '0;
      repeat (6) @(posedge core_clk);
      check(alert, 1'b0, "alert down");
    end
    bus_wr(LDS_REG_CTRL, 16'h0001);
    i_host.send({24'h01_0F0F, crc_of(24'h01_0F0F)}, 32);
    check(dac_code, 16'h0F0F, "good check byte");
    i_host.send({24'h01_F0F0, ~crc_of(24'h01_F0F0)}, 32);
    check(dac_code, 16'h0F0F, "bad check byte");
    check(alert, 1'b1, "check alert");
    bus_rd(LDS_REG_FAULT, 16'h0002);
    bus_wr(LDS_REG_FAULT, 16'h0002);
    bus_wr(LDS_REG_CTRL, 16'h0002);
    repeat (WDOG_SIM + 5) @(posedge core_clk);
    bus_rd(LDS_REG_FAULT, 16'h0001);
    check(alert, 1'b1, "link loss alert");
    bus_wr(LDS_REG_CTRL, 16'h0000);
    bus_wr(LDS_REG_FAULT, 16'h0001);
    repeat (3) @(posedge core_clk);
    check(alert, 1'b0, "cleared");
  endtask

  initial
  begin
    rst = 1'b1;
    load_output_n = 1'b0;
    ana_fault = '0;
    {alarm_dir, sense_resistor_sel, span_sel_hi, span_sel_lo} = 4'h0;
    bus_req = '0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check({dac_code, alert, load_pending}, 18'h00000, "reset state");
    bus_rd(LDS_REG_CTRL, 16'h0000);
    bus_rd(4'hF, 16'h0000);
    t_straps();
    t_frames();
    bus_wr(LDS_REG_OUTPUT, 16'h7777);
    bus_rd(LDS_REG_OUTPUT, 16'hABCD);
    t_faults();
    report_and_stop();
  end
endmodule
